// [hw/ppb_pkg.sv]
/*
 * Constants, register map and state carriers for the bulk endpoint ping-pong buffer controller.
 * Assumes one 40 MHz clock, a 32-bit AXI4-Lite master and byte counts of at most 16 bits.
 */
package ppb_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_PORT_CTL = 8'h00;
    localparam logic [7:0] ADDR_EP_CTL = 8'h04;
    localparam logic [7:0] ADDR_RX_CNT = 8'h08;
    localparam logic [7:0] ADDR_TX_CNT = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    localparam int BIT_AUTOTOG = 0;
    localparam int BIT_AUTOSTREAM = 1;
    localparam int BIT_DIR = 2;
    localparam int BIT_WSEL = 0;
    localparam int BIT_RSEL = 1;
    localparam int BIT_AFULL = 2;
    localparam int BIT_BFULL = 3;
    localparam int BIT_TXA_PEND = 4;
    localparam int BIT_TXB_PEND = 5;
    localparam int BIT_RX_HOLD = 0;
    localparam int BIT_TX_HOLD = 1;
    localparam int BIT_STREAM_BUSY = 2;

    localparam int CNT_W = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic {
        AS_IDLE = 1'b0,
        AS_DRAIN = 1'b1
    } ppb_auto_e;

    typedef struct packed {
        logic dir;
        logic auto_stream_en;
        logic rx_autotoggle_en;
    } ppb_ctl_s;

    typedef struct packed {
        ppb_ctl_s ctl;
        logic write_buffer_select;
        logic read_buffer_select;
        logic [1:0] full;
        logic [1:0] full_q;
        logic [1:0][CNT_W-1:0] rx_cnt;
        logic [1:0][CNT_W-1:0] tx_cnt;
        logic [1:0] tx_pend;
        logic [CNT_W-1:0] drained;
        ppb_auto_e auto_st;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic usb_out_nak;
        logic usb_in_nak;
        logic dma_ack_n;
    } ppb_state_s;

endpackage

// [hw/ppb_buffer_ctl.sv]
/*
 * Ping-pong buffer control for the bulk endpoint: receive toggling, transmit hand-off,
 * automatic streaming and flow control, with its registers on an AXI4-Lite slave.
 * Assumes all data-side strobes are synchronous to clock and the SRAM datapath lives outside.
 */
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
module ppb_buffer_ctl
    import ppb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Receive source (USB engine or ATA port, by direction)
    input wire logic rx_valid,
    input wire logic [2:0] rx_bytes,
    input wire logic rx_last,
    // Transmit destination
    input wire logic tx_valid,
    input wire logic [2:0] tx_bytes,
    // Handshake pins
    input wire logic ata_drq,
    output logic dma_ack_n,
    output logic usb_out_nak,
    output logic usb_in_nak,
    // Buffer selectors toward the SRAM datapath
    output logic write_buffer_select,
    output logic read_buffer_select
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic ppb_mapped(input logic [7:0] addr);
        ppb_mapped = (addr == ADDR_PORT_CTL) || (addr == ADDR_EP_CTL) || (addr == ADDR_RX_CNT) ||
                     (addr == ADDR_TX_CNT) || (addr == ADDR_STATUS);
    endfunction

    function automatic logic [31:0] ppb_merge(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        ppb_merge = res;
    endfunction

    // ****************************************
    // State
    // ****************************************
    ppb_state_s st;
    ppb_state_s next_st;

    always_comb begin
        logic wr_go;
        logic [31:0] wd;
        logic both_full;
        logic rise_a;
        logic rise_b;
        logic fall_a;
        logic fall_b;
        logic fw_wsel_wr;
        logic tx_done;
        logic pick;
        logic pb;
        logic [CNT_W-1:0] drained_sum;
        logic [31:0] rd;

        next_st = st;
        wr_go = st.aw_held && st.w_held && !st.bvalid;
        wd = 32'h0;
        fw_wsel_wr = 1'b0;
        tx_done = 1'b0;
        pick = 1'b0;
        pb = 1'b0;
        drained_sum = 16'h0000;
        rd = 32'h0;
        both_full = st.full[0] && st.full[1];
        rise_a = st.full[0] && !st.full_q[0];
        rise_b = st.full[1] && !st.full_q[1];
        fall_a = !st.full[0] && st.full_q[0];
        fall_b = !st.full[1] && st.full_q[1];

        // ****************************************
        // Bus capture and read path
        // ****************************************
        if (s_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_awaddr;
        end
        if (s_wvalid && st.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_wdata;
            next_st.w_strb = s_wstrb;
        end
        if (st.bvalid && s_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && s_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_arvalid && st.arready) begin
            unique case (s_araddr)
                ADDR_PORT_CTL: rd = {29'h0, st.ctl.dir, st.ctl.auto_stream_en, st.ctl.rx_autotoggle_en};
                ADDR_EP_CTL: rd = {26'h0, st.tx_pend, st.full, st.read_buffer_select, st.write_buffer_select};
                ADDR_RX_CNT: rd = {st.rx_cnt[1], st.rx_cnt[0]};
                ADDR_TX_CNT: rd = {st.tx_cnt[1], st.tx_cnt[0]};
                ADDR_STATUS: rd = {29'h0, st.auto_st == AS_DRAIN, st.tx_pend == 2'b00, both_full};
                default: rd = 32'h0;
            endcase
            next_st.rvalid = 1'b1;
            next_st.rdata = rd;
            next_st.rresp = ppb_mapped(s_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // ****************************************
        // Receive counting into the selected buffer
        // ****************************************
        // Data aimed at a full buffer is refused and never counted
        if (rx_valid && !st.full[st.write_buffer_select]) begin
            next_st.rx_cnt[st.write_buffer_select] = st.rx_cnt[st.write_buffer_select] + CNT_W'(rx_bytes);
        end

        // ****************************************
        // Transmit drain of the read buffer
        // ****************************************
        if (st.tx_pend[st.read_buffer_select]) begin
            drained_sum = tx_valid ? st.drained + CNT_W'(tx_bytes) : st.drained;
            next_st.drained = drained_sum;
            if (drained_sum >= st.tx_cnt[st.read_buffer_select]) begin
                tx_done = 1'b1;
                next_st.tx_pend[st.read_buffer_select] = 1'b0;
                next_st.drained = 16'h0000;
            end
        end

        // ****************************************
        // Firmware writes
        // ****************************************
        if (wr_go) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = ppb_mapped(st.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (st.aw_addr)
                ADDR_PORT_CTL: begin
                    wd = ppb_merge({29'h0, st.ctl.dir, st.ctl.auto_stream_en, st.ctl.rx_autotoggle_en},
                                   st.w_data, st.w_strb);
                    next_st.ctl.rx_autotoggle_en = wd[BIT_AUTOTOG];
                    next_st.ctl.auto_stream_en = wd[BIT_AUTOSTREAM];
                    next_st.ctl.dir = wd[BIT_DIR];
                end
                ADDR_EP_CTL: begin
                    // Selectors and flag clears belong to the stream machine while auto_stream_en is set
                    if (st.w_strb[0] && !st.ctl.auto_stream_en) begin
                        fw_wsel_wr = 1'b1;
                        next_st.write_buffer_select = st.w_data[BIT_WSEL];
                        next_st.rx_cnt[st.w_data[BIT_WSEL]] = 16'h0000;
                        next_st.read_buffer_select = st.w_data[BIT_RSEL];
                        if (st.w_data[BIT_RSEL] != st.read_buffer_select || !st.tx_pend[st.w_data[BIT_RSEL]]) begin
                            next_st.tx_pend[st.w_data[BIT_RSEL]] = 1'b1;
                            next_st.drained = 16'h0000;
                        end
                        if (st.w_data[BIT_AFULL]) begin
                            next_st.full[0] = 1'b0;
                        end
                        if (st.w_data[BIT_BFULL]) begin
                            next_st.full[1] = 1'b0;
                        end
                    end
                end
                ADDR_TX_CNT: begin
                    if (!st.ctl.auto_stream_en) begin
                        next_st.tx_cnt = ppb_merge({st.tx_cnt[1], st.tx_cnt[0]}, st.w_data, st.w_strb);
                    end
                end
                default: begin
                end
            endcase
        end

        // ****************************************
        // Receive auto-toggle on full-flag edges
        // ****************************************
        // Both full stays unchanged because no case below matches it
        if ((st.ctl.rx_autotoggle_en || st.ctl.auto_stream_en) && !fw_wsel_wr) begin
            if (rise_a && !st.full[1]) begin
                next_st.write_buffer_select = 1'b1;
                next_st.rx_cnt[1] = 16'h0000;
            end else if (rise_b && !st.full[0]) begin
                next_st.write_buffer_select = 1'b0;
                next_st.rx_cnt[0] = 16'h0000;
            end else if (fall_b && st.full[0]) begin
                next_st.write_buffer_select = 1'b1;
                next_st.rx_cnt[1] = 16'h0000;
            end else if (fall_a && st.full[1]) begin
                next_st.write_buffer_select = 1'b0;
                next_st.rx_cnt[0] = 16'h0000;
            end
        end

        // ****************************************
        // Automatic stream machine
        // ****************************************
        unique case (st.auto_st)
            AS_IDLE: begin
                if (st.ctl.auto_stream_en && st.tx_pend == 2'b00) begin
                    // Prefer the buffer not drained last, so data leaves in arrival order
                    if (st.full[!st.read_buffer_select]) begin
                        pick = 1'b1;
                        pb = !st.read_buffer_select;
                    end else if (st.full[st.read_buffer_select]) begin
                        pick = 1'b1;
                        pb = st.read_buffer_select;
                    end
                    if (pick) begin
                        next_st.tx_cnt[pb] = st.rx_cnt[pb];
                        if (st.rx_cnt[pb] == 16'h0000) begin
                            next_st.full[pb] = 1'b0;
                        end else begin
                            next_st.read_buffer_select = pb;
                            next_st.tx_pend[pb] = 1'b1;
                            next_st.drained = 16'h0000;
                            next_st.auto_st = AS_DRAIN;
                        end
                    end
                end
            end
            AS_DRAIN: begin
                if (tx_done) begin
                    next_st.full[st.read_buffer_select] = 1'b0;
                    next_st.auto_st = AS_IDLE;
                end else if (!st.ctl.auto_stream_en) begin
                    next_st.auto_st = AS_IDLE;
                end
            end
        endcase

        // Load completion last; it sets only a flag that is clear now, so one in its buffer's clearing cycle is lost
        if (rx_last && !st.full[st.write_buffer_select]) begin
            next_st.full[st.write_buffer_select] = 1'b1;
        end
        next_st.full_q = st.full;

        // ****************************************
        // Handshakes and bus ready, all registered
        // ****************************************
        next_st.usb_out_nak = !next_st.ctl.dir && (next_st.full == 2'b11);
        next_st.usb_in_nak = next_st.ctl.dir && (next_st.tx_pend == 2'b00);
        next_st.dma_ack_n = !(ata_drq && (next_st.ctl.dir ? (next_st.full != 2'b11)
                                                           : (next_st.tx_pend != 2'b00)));
        next_st.awready = !next_st.aw_held;
        next_st.wready = !next_st.w_held;
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st <= '0;
            st.dma_ack_n <= 1'b1;
            st.auto_st <= AS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_awready = st.awready;
    assign s_wready = st.wready;
    assign s_bvalid = st.bvalid;
    assign s_bresp = st.bresp;
    assign s_arready = st.arready;
    assign s_rvalid = st.rvalid;
    assign s_rdata = st.rdata;
    assign s_rresp = st.rresp;
    assign dma_ack_n = st.dma_ack_n;
    assign usb_out_nak = st.usb_out_nak;
    assign usb_in_nak = st.usb_in_nak;
    assign write_buffer_select = st.write_buffer_select;
    assign read_buffer_select = st.read_buffer_select;

endmodule

// [verif/ppb_far_end.sv]
/*
 * Far-side model of the bulk buffer: receive source and transmit sink with the DMA request.
 * Assumes the testbench calls its tasks one at a time; pins change just after the clock rises.
 */
`timescale 1ns/100ps
module ppb_far_end (
    // Clock and flow control
    input wire logic clock,
    input wire logic usb_out_nak,
    // Strobes toward the controller
    output logic rx_valid,
    output logic [2:0] rx_bytes,
    output logic rx_last,
    output logic tx_valid,
    output logic [2:0] tx_bytes,
    output logic ata_drq
);
    // ****************************************
    // Source and sink tasks
    // ****************************************
    initial begin
        rx_valid = 1'h0;
        rx_bytes = 3'h0;
        rx_last = 1'h0;
        tx_valid = 1'h0;
        tx_bytes = 3'h0;
        ata_drq = 1'h0;
    end

    task automatic load(input logic [2:0] n);
        @(posedge clock);
        if (!usb_out_nak) begin
            rx_valid <= (n != 3'h0);
            rx_bytes <= n;
            @(posedge clock);
            rx_valid <= 1'h0;
            // Released count lines never show the old value
            rx_bytes <= ~n;
            rx_last <= 1'h1;
            @(posedge clock);
            rx_last <= 1'h0;
        end
    endtask

    task automatic drain(input logic [2:0] n);
        @(posedge clock);
        tx_valid <= 1'h1;
        tx_bytes <= n;
        @(posedge clock);
        tx_valid <= 1'h0;
        tx_bytes <= ~n;
    endtask

    task automatic drq(input logic v);
        @(posedge clock);
        ata_drq <= v;
    endtask
endmodule

// [verif/ppb_buffer_ctl_monitor.sv]
/*
 * Port-level assertions for the ping-pong buffer controller.
 * Assumes one clock domain and the synchronous active-low reset of the design.
 */
`timescale 1ns/100ps
module ppb_buffer_ctl_monitor
    import ppb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Bus handshakes
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [1:0] s_bresp,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata,
    // Flow control and selector
    input wire logic ata_drq,
    input wire logic dma_ack_n,
    input wire logic usb_out_nak,
    input wire logic usb_in_nak,
    input wire logic write_buffer_select
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Firmware writes may still move the selector, so their edge is exempt
    property p_sel_frozen;
        usb_out_nak && $past(usb_out_nak) && !$rose(s_bvalid) |-> $stable(write_buffer_select);
    endproperty
    a_sel_frozen: assert property (p_sel_frozen) else $error("selector moved while both full");
    property p_ack_cause;
        !dma_ack_n |-> $past(ata_drq);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
    property p_nak_excl;
        !(usb_out_nak && usb_in_nak);
    endproperty
    a_nak_excl: assert property (p_nak_excl) else $error("both naks at once");
    property p_b_hold;
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold;
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_r_lat;
        s_arvalid && s_arready |=> s_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read answer late");
    property p_w_lat;
        s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:3] s_bvalid;
    endproperty
    a_w_lat: assert property (p_w_lat) else $error("write answer late");
    property p_ar_block;
        s_rvalid |-> !s_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("address taken during read answer");

    c_out_nak: cover property (usb_out_nak);
    c_in_nak: cover property (usb_in_nak);
    c_ack: cover property (!dma_ack_n);
    c_slverr: cover property (s_bvalid && s_bresp == RESP_SLVERR);
endmodule

bind ppb_buffer_ctl ppb_buffer_ctl_monitor u_mon (.clock, .reset_n, .s_awvalid, .s_awready, .s_wvalid, .s_wready,
    .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata, .ata_drq, .dma_ack_n,
    .usb_out_nak, .usb_in_nak, .write_buffer_select);

// [verif/tb.sv]
/*
 * Self-checking testbench of the ping-pong buffer controller.
 * Assumes the far-end model for data strobes and drives the register bus itself.
 */
`timescale 1ns/100ps
module tb;
    import ppb_pkg::*;
    // ****************************************
    // Signals, clock and instances
    // ****************************************
    logic clock = 1'h0;
    logic reset_n;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rd_data;
    logic [3:0] s_wstrb, wr_strb;
    logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, rx_valid, rx_last, tx_valid, ata_drq;
    logic dma_ack_n, usb_out_nak, usb_in_nak, write_buffer_select, read_buffer_select;
    logic [1:0] s_bresp, s_rresp, rd_resp;
    logic [2:0] rx_bytes, tx_bytes;
    int n_fail = 0;
    int n_compared = 0;

    always #12.5 clock = ~clock;

    ppb_buffer_ctl uut (.clock, .reset_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready, .rx_valid, .rx_bytes, .rx_last, .tx_valid, .tx_bytes, .ata_drq, .dma_ack_n,
        .usb_out_nak, .usb_in_nak, .write_buffer_select, .read_buffer_select);
    ppb_far_end far (.clock, .usb_out_nak, .rx_valid, .rx_bytes, .rx_last, .tx_valid, .tx_bytes, .ata_drq);

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_sim;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task tmo;
        n_fail++;
        $display("wrong value bus answer expected within bound seen none");
        end_sim;
    endtask

    task settle;
        repeat (3) @(posedge clock);
    endtask

    // Responses are accepted late on purpose so the slave must hold them
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge clock);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= wr_strb;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        for (i = 0; i < 40; i++) begin
            @(posedge clock);
            if (s_bvalid && s_bready) break;
            if (s_awready) s_awvalid <= 1'h0;
            if (s_wready) s_wvalid <= 1'h0;
            if (i == 4) s_bready <= 1'h1;
        end
        if (i == 40) tmo;
        check("bresp", 32'(s_bresp), 32'(er));
        s_bready <= 1'h0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int i;
        @(posedge clock);
        s_araddr <= a;
        s_arvalid <= 1'h1;
        for (i = 0; i < 40; i++) begin
            @(posedge clock);
            if (s_rvalid && s_rready) break;
            if (s_arready) s_arvalid <= 1'h0;
            if (i == 2) s_rready <= 1'h1;
        end
        if (i == 40) tmo;
        rd_data = s_rdata;
        rd_resp = s_rresp;
        s_rready <= 1'h0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_toggle;
        axi_wr(ADDR_PORT_CTL, 32'h1, RESP_OKAY);
        far.load(3'h4);
        settle;
        check("wsel after A", 32'(write_buffer_select), 32'h1);
        axi_rd(ADDR_EP_CTL);
        check("full A", 32'(rd_data[BIT_AFULL]), 32'h1);
        axi_rd(ADDR_RX_CNT);
        check("rx count A", 32'(rd_data[15:0]), 32'h4);
        far.load(3'h3);
        settle;
        check("out nak", 32'(usb_out_nak), 32'h1);
        check("wsel both full", 32'(write_buffer_select), 32'h1);
        axi_wr(ADDR_EP_CTL, 32'h5, RESP_OKAY);
        settle;
        check("wsel A freed", 32'(write_buffer_select), 32'h0);
        axi_rd(ADDR_RX_CNT);
        check("rx count A cleared", 32'(rd_data[15:0]), 32'h0);
        far.load(3'h2);
        settle;
        check("wsel both full", 32'(write_buffer_select), 32'h0);
        axi_wr(ADDR_EP_CTL, 32'h8, RESP_OKAY);
        settle;
        check("wsel B freed", 32'(write_buffer_select), 32'h1);
        axi_wr(ADDR_EP_CTL, 32'h5, RESP_OKAY);
        far.load(3'h1);
        settle;
        check("wsel after B", 32'(write_buffer_select), 32'h0);
        axi_wr(ADDR_EP_CTL, 32'h8, RESP_OKAY);
        axi_wr(ADDR_PORT_CTL, 32'h0, RESP_OKAY);
        far.load(3'h1);
        settle;
        check("wsel no toggle", 32'(write_buffer_select), 32'h0);
        axi_wr(ADDR_EP_CTL, 32'h4, RESP_OKAY);
    endtask

    task t_tx;
        // Lanes 1 and 3 are masked, so their bytes must keep the old zero counts
        wr_strb = 4'h5;
        axi_wr(ADDR_TX_CNT, 32'hAA03_AA06, RESP_OKAY);
        wr_strb = 4'hF;
        axi_rd(ADDR_TX_CNT);
        check("tx count strobes", rd_data, 32'h0003_0006);
        far.drq(1'h1);
        settle;
        check("ack idle", 32'(dma_ack_n), 32'h1);
        axi_wr(ADDR_EP_CTL, 32'h0, RESP_OKAY);
        settle;
        check("ack pending", 32'(dma_ack_n), 32'h0);
        far.drain(3'h4);
        settle;
        check("ack part drained", 32'(dma_ack_n), 32'h0);
        far.drain(3'h2);
        settle;
        check("ack drained", 32'(dma_ack_n), 32'h1);
        axi_wr(ADDR_EP_CTL, 32'h2, RESP_OKAY);
        settle;
        check("rsel B", 32'(read_buffer_select), 32'h1);
        check("ack B pending", 32'(dma_ack_n), 32'h0);
        far.drain(3'h3);
        settle;
        check("ack B drained", 32'(dma_ack_n), 32'h1);
        far.drq(1'h0);
    endtask

    task t_dir1;
        axi_wr(ADDR_PORT_CTL, 32'h5, RESP_OKAY);
        far.drq(1'h1);
        settle;
        check("ack room", 32'(dma_ack_n), 32'h0);
        check("in nak", 32'(usb_in_nak), 32'h1);
        far.load(3'h3);
        far.load(3'h3);
        settle;
        check("ack both full", 32'(dma_ack_n), 32'h1);
        check("out nak dir1", 32'(usb_out_nak), 32'h0);
        far.drq(1'h0);
        axi_wr(ADDR_EP_CTL, 32'hC, RESP_OKAY);
        settle;
        check("in nak pending", 32'(usb_in_nak), 32'h0);
        far.drain(3'h6);
        settle;
        check("in nak drained", 32'(usb_in_nak), 32'h1);
        axi_wr(ADDR_PORT_CTL, 32'h0, RESP_OKAY);
    endtask

    task t_auto;
        axi_wr(ADDR_PORT_CTL, 32'h2, RESP_OKAY);
        far.load(3'h5);
        settle;
        axi_rd(ADDR_TX_CNT);
        check("tx count copy", 32'(rd_data[15:0]), 32'h5);
        axi_rd(ADDR_STATUS);
        check("stream busy", 32'(rd_data[BIT_STREAM_BUSY]), 32'h1);
        far.drain(3'h5);
        settle;
        axi_rd(ADDR_EP_CTL);
        check("full A auto clear", 32'(rd_data[BIT_AFULL]), 32'h0);
        far.load(3'h0);
        settle;
        axi_rd(ADDR_STATUS);
        check("zero no launch", 32'(rd_data[BIT_STREAM_BUSY]), 32'h0);
        axi_rd(ADDR_EP_CTL);
        check("zero flags", rd_data & 32'h3C, 32'h0);
        axi_wr(ADDR_PORT_CTL, 32'h0, RESP_OKAY);
    endtask

    task t_unmapped;
        axi_wr(8'h20, 32'h1, RESP_SLVERR);
        axi_rd(8'h20);
        check("rresp", 32'(rd_resp), 32'(RESP_SLVERR));
        check("rdata", rd_data, 32'h0);
    endtask

    initial begin
        reset_n <= 1'h0;
        s_awaddr <= 8'h00;
        s_araddr <= 8'h00;
        s_wdata <= 32'h0;
        s_wstrb <= 4'hF;
        s_awvalid <= 1'h0;
        s_wvalid <= 1'h0;
        s_bready <= 1'h0;
        s_arvalid <= 1'h0;
        s_rready <= 1'h0;
        wr_strb = 4'hF;
        repeat (16) @(posedge clock);
        check("reset outs", 32'({dma_ack_n, usb_out_nak, usb_in_nak, write_buffer_select, read_buffer_select,
            s_bvalid, s_rvalid, s_awready}), 32'h80);
        reset_n <= 1'h1;
        repeat (2) @(posedge clock);
        t_toggle;
        t_tx;
        t_dir1;
        t_auto;
        t_unmapped;
        end_sim;
    end
endmodule
